/* File: hw/adc_config_pin_decode.sv */
`timescale 1ns/10ps
// Function
// RQ1 - Oversampling ratio from three select lines, line 2 most significant.
// RQ2 - Interface select low gives the 16-bit parallel bus.
// RQ3 - Interface select high without byte qualifier gives the serial interface.
// RQ4 - Byte mode only when interface select and data line 15 are high.
// RQ5 - Read strobe doubles as serial shift clock in serial mode.
// RQ6 - Serial outputs are data line 7 first, data line 8 second.
// RQ7 - Host ties unused data lines low while serial mode is chosen.
// RQ8 - In byte mode data line 14 picks which result half is shown.
// RQ9 - Byte mode moves each result over lines 7..0 in two reads.
// RQ10 - Standby request enters one of two power-down modes, range picks which.
// RQ11 - Light power-down keeps only reference and regulators alive.
// RQ12 - Deep power-down switches everything off.
// RQ13 - Chip select fall shows MSB, each shift clock rise the next bit.
// RQ14 - Parallel bus driven only while chip select and read are both low.
module adc_config_pin_decode
  import adc_pin_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rd_sclk,
  input wire logic chip_select_n,
  input wire logic [OS_W-1:0] oversample_ratio_sel,
  input wire logic interface_kind_sel,
  input wire logic power_down_request,
  input wire logic range_sel,
  input wire logic [RESULT_W-1:0] parallel_result_bus_in,
  output logic [RESULT_W-1:0] parallel_result_bus_out,
  output logic [RESULT_W-1:0] parallel_result_bus_oe_n,
  input wire logic result_valid,
  input wire logic [RESULT_W-1:0] result_data,
  output logic result_ready,
  output logic [OS_W-1:0] oversample_ratio,
  output iface_mode_e iface_mode,
  output power_ctrl_s power_ctrl
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  cfg_pins_s cfg_meta, cfg_s;
  logic [2:0] strb_meta, strb_s;
  logic cs_s, rd_s, qual_s, upper_byte_enable_s;
  logic [BIT_CNT_W-1:0] gray_meta, gray_s, link_gray;

  // Two stages for every pin; only the second stage is read
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cfg_meta <= '0;
      cfg_s <= '0;
      // Idle levels: select and read high, qualifier low, so no false edge follows reset
      strb_meta <= 3'h6;
      strb_s <= 3'h6;
      gray_meta <= '0;
      gray_s <= '0;
    end
    else
    begin
      cfg_meta <= {oversample_ratio_sel, interface_kind_sel, power_down_request, range_sel};
      cfg_s <= cfg_meta;
      strb_meta <= {chip_select_n, rd_sclk, parallel_result_bus_in[BYTE_QUALIFIER_BIT]};
      strb_s <= strb_meta;
      gray_meta <= link_gray;
      gray_s <= gray_meta;
    end
  end

  // Upper byte enable only matters in byte mode, sync it alongside
  logic upper_byte_enable_meta;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      upper_byte_enable_meta <= 1'b0;
      upper_byte_enable_s <= 1'b0;
    end
    else
    begin
      upper_byte_enable_meta <= parallel_result_bus_in[UPPER_BYTE_ENABLE_BIT];
      upper_byte_enable_s <= upper_byte_enable_meta;
    end
  end

  assign cs_s = strb_s[2];
  assign rd_s = strb_s[1];
  assign qual_s = strb_s[0];

  // ****************************************
  // Link domain: serial shift counter
  // ****************************************
  // Shift clock only runs inside a frame, so chip select high clears it
  logic [BIT_CNT_W-1:0] link_cnt, next_link_cnt;

  always_comb
  begin
    next_link_cnt = link_cnt;
    if (link_cnt != SERIAL_BITS)
      next_link_cnt = BIT_CNT_W'(link_cnt + 1'b1); // RQ5 RQ13
  end

  always_ff @(posedge rd_sclk or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      link_cnt <= '0;
      link_gray <= '0;
    end
    else
    begin
      link_cnt <= next_link_cnt;
      link_gray <= next_link_cnt ^ (next_link_cnt >> 1);
    end
  end

  // Gray back to binary in the core domain
  logic [BIT_CNT_W-1:0] bit_idx;
  always_comb
  begin
    bit_idx[BIT_CNT_W-1] = gray_s[BIT_CNT_W-1];
    for (int i = BIT_CNT_W - 2; i >= 0; i--)
      bit_idx[i] = bit_idx[i+1] ^ gray_s[i];
  end

  // ****************************************
  // Result buffer
  // ****************************************
  logic fifo_valid, fifo_ready;
  logic [RESULT_W-1:0] fifo_data;

  result_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .in_data(result_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // ****************************************
  // Word staging and read tracking
  // ****************************************
  logic [RESULT_W-1:0] word_a, word_b, next_word_a, next_word_b;
  logic valid_a, valid_b, next_valid_a, next_valid_b;
  logic cs_d, rd_d, byte_phase, next_byte_phase, frame_done, next_frame_done;
  logic rd_end, consume, shift_pair;

  // Words only load while idle so a frame sees stable data
  always_comb
  begin
    rd_end = rd_s && !rd_d && !cs_s;
    consume = 1'b0;
    shift_pair = 1'b0;
    next_byte_phase = byte_phase;
    next_frame_done = frame_done;
    if (iface_mode == MODE_PARALLEL && rd_end)
      shift_pair = 1'b1;
    if (iface_mode == MODE_BYTE && rd_end)
    begin
      next_byte_phase = !byte_phase; // RQ9
      shift_pair = byte_phase;
    end
    if (iface_mode == MODE_SERIAL && !cs_s && bit_idx == SERIAL_BITS)
      next_frame_done = 1'b1;
    if (cs_s && !cs_d && frame_done)
    begin
      consume = 1'b1;
      next_frame_done = 1'b0;
    end
    next_word_a = word_a;
    next_word_b = word_b;
    next_valid_a = valid_a;
    next_valid_b = valid_b;
    fifo_ready = 1'b0;
    if (consume)
    begin
      next_valid_a = 1'b0;
      next_valid_b = 1'b0;
    end
    else if (shift_pair)
    begin
      next_word_a = word_b;
      next_valid_a = valid_b;
      next_valid_b = 1'b0;
    end
    else if (cs_s && fifo_valid && !(valid_a && valid_b))
    begin
      fifo_ready = 1'b1;
      if (!valid_a)
      begin
        next_word_a = fifo_data;
        next_valid_a = 1'b1;
      end
      else
      begin
        next_word_b = fifo_data;
        next_valid_b = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      word_a <= BUS_ZERO;
      word_b <= BUS_ZERO;
      valid_a <= 1'b0;
      valid_b <= 1'b0;
      cs_d <= 1'b1;
      rd_d <= 1'b1;
      byte_phase <= 1'b0;
      frame_done <= 1'b0;
    end
    else
    begin
      word_a <= next_word_a;
      word_b <= next_word_b;
      valid_a <= next_valid_a;
      valid_b <= next_valid_b;
      cs_d <= cs_s;
      rd_d <= rd_s;
      byte_phase <= next_byte_phase;
      frame_done <= next_frame_done;
    end
  end

  // ****************************************
  // Mode decode, pin drive and power control
  // ****************************************
  iface_mode_e next_mode;
  power_state_e pwr_state, next_pwr_state;
  power_ctrl_s next_power_ctrl;
  logic [RESULT_W-1:0] next_bus_out, next_bus_oe_n, shown_a, shown_b;
  logic [OS_W-1:0] next_os;
  logic power_down_request_d, drive;
  logic [3:0] sel;

  // Pins unused by a mode stay released; serial relies on board ties
  always_comb
  begin
    next_os = cfg_s.oversample_ratio_sel; // RQ1
    if (!cfg_s.interface_kind_sel)
      next_mode = MODE_PARALLEL; // RQ2
    else if (qual_s)
      next_mode = MODE_BYTE; // RQ4
    else
      next_mode = MODE_SERIAL; // RQ3
    shown_a = valid_a ? word_a : BUS_ZERO;
    shown_b = valid_b ? word_b : BUS_ZERO;
    drive = !cs_s && !rd_s;
    sel = 4'(SERIAL_BITS - 1'b1 - bit_idx[3:0]);
    next_bus_out = BUS_ZERO;
    next_bus_oe_n = BUS_RELEASED;
    case (iface_mode)
      MODE_PARALLEL:
      begin
        next_bus_out = shown_a;
        if (drive)
          next_bus_oe_n = BUS_ZERO; // RQ14
      end
      MODE_BYTE:
      begin
        next_bus_out[BYTE_W-1:0] = upper_byte_enable_s ? shown_a[RESULT_W-1:BYTE_W]
                                          : shown_a[BYTE_W-1:0]; // RQ8 RQ9
        if (drive)
          next_bus_oe_n = BYTE_DRIVE_N;
      end
      MODE_SERIAL:
      begin
        if (!cs_s)
        begin
          next_bus_oe_n = SERIAL_DRIVE_N; // RQ6 RQ7
          if (bit_idx < SERIAL_BITS)
          begin
            next_bus_out[SERIAL_OUT_FIRST_BIT] = shown_a[sel]; // RQ13
            next_bus_out[SERIAL_OUT_SECOND_BIT] = shown_b[sel];
          end
        end
      end
      default:
      begin
        next_bus_out = BUS_ZERO;
        next_bus_oe_n = BUS_RELEASED;
      end
    endcase
    // Range is caught at the request edge and held until release
    next_pwr_state = pwr_state;
    case (pwr_state)
      PWR_ACTIVE:
        if (cfg_s.power_down_request && !power_down_request_d)
          next_pwr_state = cfg_s.range_sel ? PWR_STANDBY : PWR_SHUTDOWN; // RQ10
      PWR_STANDBY, PWR_SHUTDOWN:
        if (!cfg_s.power_down_request)
          next_pwr_state = PWR_ACTIVE;
      default:
        next_pwr_state = PWR_ACTIVE;
    endcase
    case (next_pwr_state)
      PWR_STANDBY: next_power_ctrl = PWR_STANDBY_CTRL; // RQ11
      PWR_SHUTDOWN: next_power_ctrl = PWR_ALL_OFF; // RQ12
      default: next_power_ctrl = PWR_ALL_ON;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      oversample_ratio <= OS_RESET;
      iface_mode <= MODE_PARALLEL;
      parallel_result_bus_out <= BUS_ZERO;
      parallel_result_bus_oe_n <= BUS_RELEASED;
      pwr_state <= PWR_ACTIVE;
      power_ctrl <= PWR_ALL_ON;
      power_down_request_d <= 1'b0;
    end
    else
    begin
      oversample_ratio <= next_os;
      iface_mode <= next_mode;
      parallel_result_bus_out <= next_bus_out;
      parallel_result_bus_oe_n <= next_bus_oe_n;
      pwr_state <= next_pwr_state;
      power_ctrl <= next_power_ctrl;
      power_down_request_d <= cfg_s.power_down_request;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_os_bit_order: assert property (##1 oversample_ratio == $past(cfg_s.oversample_ratio_sel)) // RQ1
    else $error("oversample ratio not taken from select lines");
  a_par_mode_entry: assert property (!cfg_s.interface_kind_sel |=> iface_mode == MODE_PARALLEL) // RQ2
    else $error("parallel mode not entered");
  a_ser_mode_entry: assert property (cfg_s.interface_kind_sel && !qual_s
                                     |=> iface_mode == MODE_SERIAL) // RQ3
    else $error("serial mode not entered");
  a_byte_mode_entry: assert property (cfg_s.interface_kind_sel && qual_s
                                      |=> iface_mode == MODE_BYTE) // RQ4
    else $error("byte mode not entered");
  a_ser_out_pins: assert property (iface_mode == MODE_SERIAL && !cs_s
                                   |=> parallel_result_bus_oe_n == SERIAL_DRIVE_N) // RQ6
    else $error("serial outputs not on lines 7 and 8");
  a_ser_msb_first: assert property (iface_mode == MODE_SERIAL && !cs_s && bit_idx == '0
                                    && valid_a |=> parallel_result_bus_out[SERIAL_OUT_FIRST_BIT]
                                    == $past(word_a[RESULT_W-1])) // RQ13
    else $error("serial frame does not start with msb");
  a_byte_half_sel: assert property (iface_mode == MODE_BYTE && upper_byte_enable_s && valid_a
                                    |=> parallel_result_bus_out[BYTE_W-1:0]
                                    == $past(word_a[RESULT_W-1:BYTE_W])) // RQ8
    else $error("upper byte not shown");
  a_par_bus_drive: assert property (iface_mode == MODE_PARALLEL
                                    |=> (parallel_result_bus_oe_n == BUS_ZERO)
                                    == $past(!cs_s && !rd_s)) // RQ14
    else $error("parallel bus drive does not follow strobes");
  a_standby_keep: assert property (pwr_state == PWR_ACTIVE && cfg_s.power_down_request
                                   && !power_down_request_d && cfg_s.range_sel
                                   |=> power_ctrl == PWR_STANDBY_CTRL [*1]) // RQ10 RQ11
    else $error("standby keeps wrong circuits on");
  a_shutdown_all: assert property (pwr_state == PWR_ACTIVE && cfg_s.power_down_request
                                   && !power_down_request_d && !cfg_s.range_sel
                                   |=> power_ctrl == PWR_ALL_OFF) // RQ10 RQ12
    else $error("shutdown leaves circuits on");
  a_byte_two_reads: assert property (iface_mode == MODE_BYTE && rd_end && !byte_phase
                                     |=> byte_phase && word_a == $past(word_a)) // RQ9
    else $error("byte mode advanced after one read");

  c_parallel_read: cover property (iface_mode == MODE_PARALLEL && rd_end && valid_a);
  c_byte_pair: cover property (iface_mode == MODE_BYTE && rd_end && byte_phase);
  c_serial_frame: cover property (consume);
  c_shutdown: cover property (pwr_state == PWR_SHUTDOWN);
endmodule : adc_config_pin_decode

/* File: hw/adc_pin_pkg.sv */
package adc_pin_pkg;
  // ****************************************
  // Widths and pin positions
  // ****************************************
  localparam int RESULT_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int BYTE_W = 8;
  localparam int OS_W = 3;
  localparam int BIT_CNT_W = 5;
  localparam int SERIAL_OUT_FIRST_BIT = 7;
  localparam int SERIAL_OUT_SECOND_BIT = 8;
  localparam int UPPER_BYTE_ENABLE_BIT = 14;
  localparam int BYTE_QUALIFIER_BIT = 15;
  localparam logic [BIT_CNT_W-1:0] SERIAL_BITS = 5'h10;

  // ****************************************
  // Reset values and drive patterns
  // ****************************************
  localparam logic [RESULT_W-1:0] BUS_RELEASED = 16'hffff;
  localparam logic [RESULT_W-1:0] BUS_ZERO = 16'h0000;
  localparam logic [RESULT_W-1:0] SERIAL_DRIVE_N = 16'hfe7f;
  localparam logic [RESULT_W-1:0] BYTE_DRIVE_N = 16'hff00;
  localparam logic [OS_W-1:0] OS_RESET = 3'h0;

  // ****************************************
  // Modes and states
  // ****************************************
  typedef enum logic [1:0] {
    MODE_PARALLEL = 2'b00,
    MODE_SERIAL = 2'b01,
    MODE_BYTE = 2'b10
  } iface_mode_e;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_SHUTDOWN = 2'b10
  } power_state_e;

  // Static configuration pins, after synchronising
  typedef struct packed {
    logic [OS_W-1:0] oversample_ratio_sel;
    logic interface_kind_sel;
    logic power_down_request;
    logic range_sel;
  } cfg_pins_s;

  // Power switches handed to the analog side
  typedef struct packed {
    logic core_on;
    logic reference_on;
    logic regulators_on;
  } power_ctrl_s;

  localparam power_ctrl_s PWR_ALL_ON = 3'b111;
  localparam power_ctrl_s PWR_STANDBY_CTRL = 3'b011;
  localparam power_ctrl_s PWR_ALL_OFF = 3'b000;
endpackage : adc_pin_pkg

/* File: hw/result_fifo.sv */
`timescale 1ns/10ps
module result_fifo
  import adc_pin_pkg::*;
#(
  parameter int WIDTH = RESULT_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // ****************************************
  // Pointer and level bookkeeping
  // ****************************************
  // Ready and valid are registered flags so that neither side sees a comb path
  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = (AW+1)'(count + (AW+1)'(push) - (AW+1)'(pop));
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  // Storage, one word per entry
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  assign out_data = mem[rd_ptr];
endmodule : result_fifo

/* File: verification/host_model.sv */
`timescale 1ns/10ps
// Host controller on the far side of the pin interface
module host_model
  import adc_pin_pkg::*;
(
  input wire logic [RESULT_W-1:0] data_wire,
  input wire logic [RESULT_W-1:0] device_oe_n,
  output logic chip_select_n,
  output logic rd_sclk,
  output logic [RESULT_W-1:0] host_drive
);
  logic qual;
  logic upper_byte_enable;
  logic tie_low;
  logic [RESULT_W-1:0] float_pat;

  // Strobes idle high; the shift clock only moves inside a frame
  initial
  begin
    chip_select_n = 1'b1;
    rd_sclk = 1'b1;
    qual = 1'b0;
    upper_byte_enable = 1'b0;
    tie_low = 1'b0;
    float_pat = 16'h5a5a;
  end

  // Undriven lines wander so a stale value never passes for data
  always #7.3 float_pat = ~float_pat;
  assign host_drive = {qual, upper_byte_enable, tie_low ? 14'h0000 : float_pat[13:0]};

  // ****************************************
  // Read cycles
  // ****************************************
  // Parallel or byte read; rd rises before cs so the word advances
  task automatic strobe_read(output logic [RESULT_W-1:0] d, output logic [RESULT_W-1:0] oe);
    #1.3;
    chip_select_n = 1'b0;
    rd_sclk = 1'b0;
    #40;
    d = data_wire;
    oe = device_oe_n;
    rd_sclk = 1'b1;
    #10;
    chip_select_n = 1'b1;
    #40;
  endtask : strobe_read

  // Serial frame: 16 rising shift edges, 30 ns apart, sampled late
  task automatic serial_frame(output logic [RESULT_W-1:0] a, output logic [RESULT_W-1:0] b,
                              output logic [RESULT_W-1:0] oe);
    #1.3;
    rd_sclk = 1'b0;
    chip_select_n = 1'b0;
    for (int k = 0; k < RESULT_W; k++)
    begin
      #18;
      a[RESULT_W-1-k] = data_wire[7];
      b[RESULT_W-1-k] = data_wire[8];
      if (k == 4)
        oe = device_oe_n;
      #2 rd_sclk = 1'b1;
      #10 rd_sclk = 1'b0;
    end
    #20 chip_select_n = 1'b1;
    rd_sclk = 1'b1;
    #60;
  endtask : serial_frame
endmodule : host_model

/* File: verification/adc_config_pin_decode_test.sv */
`timescale 1ns/10ps
module adc_config_pin_decode_test
  import adc_pin_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [OS_W-1:0] os_sel = 3'h0;
  logic kind_sel = 1'b0;
  logic pd_req = 1'b0;
  logic range_sel = 1'b0;
  logic result_valid = 1'b0;
  logic [RESULT_W-1:0] result_data = 16'h0000;
  logic result_ready;
  logic chip_select_n;
  logic rd_sclk;
  logic [RESULT_W-1:0] bus_out;
  logic [RESULT_W-1:0] oe_n;
  logic [RESULT_W-1:0] host_drive;
  logic [RESULT_W-1:0] data_wire;
  logic [OS_W-1:0] ratio;
  iface_mode_e mode;
  power_ctrl_s pwr;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'h3725;
  logic [RESULT_W-1:0] exp_q[$];
  logic [RESULT_W-1:0] w;
  logic [RESULT_W-1:0] d;
  logic [RESULT_W-1:0] d2;
  logic [RESULT_W-1:0] got_b;
  logic [RESULT_W-1:0] oe;
  logic ok;

  // Wire level: device wins where it enables its driver
  assign data_wire = (bus_out & ~oe_n) | (host_drive & oe_n);
  always #2.5 core_clk = ~core_clk;

  adc_config_pin_decode uut (.core_clk(core_clk), .rst(rst), .rd_sclk(rd_sclk),
    .chip_select_n(chip_select_n), .oversample_ratio_sel(os_sel), .interface_kind_sel(kind_sel),
    .power_down_request(pd_req), .range_sel(range_sel), .parallel_result_bus_in(data_wire),
    .parallel_result_bus_out(bus_out), .parallel_result_bus_oe_n(oe_n),
    .result_valid(result_valid), .result_data(result_data), .result_ready(result_ready),
    .oversample_ratio(ratio), .iface_mode(mode), .power_ctrl(pwr));

  host_model host (.data_wire(data_wire), .device_oe_n(oe_n), .chip_select_n(chip_select_n),
    .rd_sclk(rd_sclk), .host_drive(host_drive));

  // ****************************************
  // Expectations and comparisons
  // ****************************************
  function automatic iface_mode_e expected_mode(input logic sel, input logic qual);
    return !sel ? MODE_PARALLEL : (qual ? MODE_BYTE : MODE_SERIAL);
  endfunction : expected_mode

  // Range high keeps reference and regulators alive
  function automatic power_ctrl_s expected_power(input logic req, input logic rng);
    return !req ? PWR_ALL_ON : (rng ? power_ctrl_s'(3'b011) : power_ctrl_s'(3'b000));
  endfunction : expected_power

  task automatic compare_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : compare_word

  task automatic compare_field(input string name, input logic [2:0] exp, input logic [2:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : compare_field

  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // Word offered at a falling edge only while ready stands high, so it is never withdrawn
  task automatic push(input logic [15:0] word, output logic taken);
    taken = (result_ready === 1'b1);
    result_valid = taken;
    result_data = word;
    @(negedge core_clk);
  endtask : push

  task automatic settle();
    repeat (8) @(negedge core_clk);
  endtask : settle

  // Hang guard, far above the roughly one thousand cycles the run needs
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    settle();
    // Mode decode, ratio and power-down for all four interface select and qualifier combinations
    for (int i = 0; i < 4; i++)
    begin
      os_sel = 3'($random(seed));
      kind_sel = i[1];
      host.qual = i[0];
      range_sel = i[0];
      pd_req = 1'b0;
      settle();
      compare_field("ratio", os_sel, ratio);
      compare_field("mode", {1'b0, expected_mode(i[1], i[0])}, {1'b0, mode});
      compare_field("power_on", expected_power(1'b0, 1'b0), pwr);
      pd_req = 1'b1;
      settle();
      compare_field("power_down", expected_power(1'b1, i[0]), pwr);
      range_sel = ~range_sel;
      settle();
      compare_field("power_held", expected_power(1'b1, i[0]), pwr);
    end
    pd_req = 1'b0;
    // Byte mode: one word over the low lines in two reads
    kind_sel = 1'b1;
    host.qual = 1'b1;
    host.tie_low = 1'b1;
    w = 16'($random(seed));
    push(w, ok);
    result_valid = 1'b0;
    settle();
    host.upper_byte_enable = 1'b1;
    host.strobe_read(d, oe);
    compare_word("byte_upper", {8'h00, w[15:8]}, {8'h00, d[7:0]});
    compare_word("byte_oe_n", 16'hff00, oe);
    host.upper_byte_enable = 1'b0;
    host.strobe_read(d, oe);
    compare_word("byte_lower", {8'h00, w[7:0]}, {8'h00, d[7:0]});
    // Serial mode: two words shifted out on the two outputs
    host.qual = 1'b0;
    w = 16'($random(seed));
    d2 = 16'h8001;
    // Host reads end off the clock grid; realign before driving the word port
    @(negedge core_clk);
    push(w, ok);
    push(d2, ok);
    result_valid = 1'b0;
    settle();
    compare_field("mode_serial", {1'b0, MODE_SERIAL}, {1'b0, mode});
    host.serial_frame(d, got_b, oe);
    compare_word("serial_first", w, d);
    compare_word("serial_second", d2, got_b);
    compare_word("serial_oe_n", 16'hfe7f, oe);
    // Parallel mode: fill the buffer until refused, then drain it in order
    @(negedge core_clk);
    kind_sel = 1'b0;
    host.tie_low = 1'b0;
    settle();
    for (int i = 0; i < 40; i++)
    begin
      w = (i == 0) ? 16'hffff : ((i == 1) ? 16'h0000 : 16'($random(seed)));
      push(w, ok);
      if (ok)
        exp_q.push_back(w);
    end
    result_valid = 1'b0;
    compare_field("fill_bounded", 3'h1, {2'b00, exp_q.size() >= 32 && exp_q.size() <= 34});
    settle();
    while (exp_q.size() > 0)
    begin
      host.strobe_read(d, oe);
      compare_word("parallel_data", exp_q.pop_front(), d);
      compare_word("parallel_oe_n", 16'h0000, oe);
    end
    host.strobe_read(d, oe);
    compare_word("empty_read", 16'h0000, d);
    compare_word("idle_oe_n", 16'hffff, oe_n);
    stop_test();
  end
endmodule : adc_config_pin_decode_test
